/* hw/cfg2_consts.svh */
`ifndef CFG2_CONSTS_SVH
`define CFG2_CONSTS_SVH
// Behaviour
// [RULE_01] Third-IO reset enable arms IO3 as reset when idle, unquad or not quad-command
// [RULE_02] Two-bit drive strength field, rewritable by the host at any time
// [RULE_03] Quad-command mode takes every byte four bits wide, else serially on IO0
// [RULE_04] Quad-command mode forces quad active; leaving it keeps quad enable untouched
// [RULE_05] Enter-quad instruction sets quad-command mode, exit-quad instruction clears it
// [RULE_06] Neither bit set: single-line mode, IO2 write protect, IO3 reset
// [RULE_07] Quad enable only: quad-line mode, IO2 data, IO3 data or reset
// [RULE_08] Quad-command mode: quad reads only, IO2 data, IO3 data or reset
// [RULE_09] Protection select bit picks legacy block protection or individual block lock
// [RULE_10] Boot address length bit is read-only and mirrors the nonvolatile boot length
// [RULE_11] Current address length picks three or four bytes; reset copies boot length
// [RULE_12] Enter-wide-address sets four-byte mode, exit-wide-address returns to three bytes
// [RULE_13] Reprogramming the boot length bit also updates the current address length
// [RULE_14] Read-config2 and read-any-register return the volatile config2 contents
// [RULE_15] Host issues volatile write enable before write-registers or write-any-register
// [RULE_16] Any reset copies nonvolatile config3 into the volatile copy used afterwards
// [RULE_17] Burst wrap applies only to main array reads, never to register reads
// [RULE_18] Read-config3 returns config3; set-burst-length writes its volatile copy
// [RULE_19] Config2 bit 4 is reserved and has no function
// [RULE_20] Quad-command mode switch settles within a fixed time before the next frame
// [RULE_21] Reserved bit reads as zero and ignores writes
`define CLK_MHZ          100
`define T_QEN_NS         1000
`define OP_ENTER_QUAD    8'h38
`define OP_EXIT_QUAD     8'hF5
`define OP_ENTER_WIDE    8'hB7
`define OP_EXIT_WIDE     8'hE9
`define OP_RD_CFG2       8'h15
`define OP_RD_CFG3       8'h33
`define OP_RD_ANY        8'h65
`define OP_WR_ANY        8'h71
`define OP_WR_REGS       8'h01
`define OP_WR_EN_VOL     8'h50
`define OP_SET_BURST     8'h77
`define OP_QUAD_RD       8'hEB
`define OP_QUAD_RD_WIDE  8'hEC
`define CFG2_THIRD_IO_RESET_ENABLE        7
`define CFG2_DRV_HI      6
`define CFG2_DRV_LO      5
`define CFG2_QPI         3
`define CFG2_WPS         2
`define CFG2_ADP         1
`define CFG2_ADS         0
`define CFG2_WR_MASK     8'hED
`define CFG3_WRAP_DIS    4
`define CFG2_RESET       8'h00
`define CFG3_RESET       8'h00
`define ADDR_CFG2V       32'h00800003
`define ADDR_CFG3V       32'h00800004
`define WRR_POS_CFG2     3'h3
`define WRR_POS_CFG3     3'h4
`endif

/* hw/cfg2_pkg.sv */
package cfg2_pkg;
  typedef enum logic [1:0] {LINE_SINGLE, LINE_QUAD, LINE_QUAD_CMD} line_mode_e;
  typedef enum logic [2:0] {CMD_IDLE, CMD_WR_REGS, CMD_WR_ANY_ADDR, CMD_WR_ANY_DATA, CMD_BURST,
                            CMD_DONE} cmd_state_e;
endpackage

/* hw/link_rx_if.sv */
interface link_rx_if;
  logic [7:0] rx_byte;
  logic       rx_done;
  logic       rx_first;
  logic       rx_toggle;
  logic       quad_mode;
  modport deser (output rx_byte, rx_done, rx_first, rx_toggle, input quad_mode);
  modport sink  (input rx_byte, rx_done, rx_first, rx_toggle, output quad_mode);
endinterface

/* hw/sync_agree.sv */
module sync_agree #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      q    <= INIT;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) q <= s3_q;
    end
  end
endmodule // sync_agree

/* hw/link_deser.sv */
module link_deser (
  input  wire logic       sck,
  input  wire logic       rst_b,
  input  wire logic       frame_rst,
  input  wire logic [3:0] io_in,
  link_rx_if.deser        rx
);
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic       first_q;
  logic       done_q;
  logic [7:0] byte_q;
  logic       frst_q;
  logic       tog_q;
  logic [7:0] sh_d;
  logic [2:0] cnt_d;
  logic       last;

  always_comb begin
    if (rx.quad_mode) begin
      sh_d  = {sh_q[3:0], io_in};  // RULE_03
      cnt_d = cnt_q + 3'h4;
    end else begin
      sh_d  = {sh_q[6:0], io_in[0]};  // RULE_03
      cnt_d = cnt_q + 3'h1;
    end
    last = (cnt_d == 3'h0);
  end

  // Frame state clears while chip select is high
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_q   <= 3'h0;
      sh_q    <= 8'h00;
      first_q <= 1'b1;
      done_q  <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      done_q <= last;
      if (last) first_q <= 1'b0;
    end
  end

  // Byte and toggle outlive the frame for the system side
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      byte_q <= 8'h00;
      frst_q <= 1'b0;
      tog_q  <= 1'b0;
    end else if (last) begin
      byte_q <= sh_d;
      frst_q <= first_q;
      tog_q  <= ~tog_q;
    end
  end

  assign rx.rx_byte   = byte_q;
  assign rx.rx_done   = done_q;
  assign rx.rx_first  = frst_q;
  assign rx.rx_toggle = tog_q;
endmodule // link_deser

/* hw/cfg2_mode_ctl.sv */
`include "cfg2_consts.svh"

module cfg2_mode_ctl import cfg2_pkg::*; #(
  parameter int T_QEN_NS = `T_QEN_NS,
  parameter int CLK_MHZ  = `CLK_MHZ
) (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_in,
  output logic      [3:0] io_out,
  output logic      [3:0] io_oe,
  input  wire logic [7:0] config2_nonvolatile,
  input  wire logic [7:0] config3_nonvolatile,
  input  wire logic       nv_update,
  input  wire logic       quad_enable,
  input  wire logic       soft_reset,
  output logic      [7:0] config2_volatile,
  output logic      [7:0] config3_volatile,
  output logic      [1:0] drive_strength_select,
  output logic            protect_method_select,
  output logic            current_addr_len,
  output logic            quad_active,
  output logic      [1:0] line_mode,
  output logic            wp_on_io2,
  output logic            io3_reset_armed,
  output logic            device_reset,
  output logic            array_wrap_active
);
  localparam int QEN_CYC = (T_QEN_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W   = $clog2(QEN_CYC + 1);

  link_rx_if rx_bus ();

  logic             frame_rst;
  logic             cs_hi_s;
  logic             io3_s;
  logic             tog_s;
  logic             tog_seen_q;
  logic             rx_evt;
  logic             op_evt;
  logic             data_evt;
  logic             load_pending_q;
  logic             hw_rst_q;
  logic             reload;
  logic             armed;
  cmd_state_e       state_q;
  logic [2:0]       idx_q;
  logic [2:0]       acnt_q;
  logic [31:0]      addr_q;
  logic             wel_q;
  logic             array_rd_q;
  logic [7:0]       cfg2_q;
  logic [7:0]       cfg3_q;
  logic [7:0]       cfg2_rd;
  logic             wr2_en;
  logic             wr3_en;
  logic [2:0]       addr_last;
  logic             qpi_seen_q;
  logic [CNT_W-1:0] settle_q;
  logic [7:0]       snap_cfg2_q;
  logic [7:0]       snap_cfg3_q;
  logic             snap_qpi_q;
  logic             snap_ads_q;
  line_mode_e       lm_d;
  logic             tx_act_q;
  logic [3:0]       out_q;
  logic [3:0]       oe_q;
  logic [7:0]       tx_sh_q;
  logic [7:0]       tx_val_q;
  logic [2:0]       tx_cnt_q;
  logic             rd_any_q;
  logic [2:0]       racnt_q;
  logic [31:0]      raddr_q;
  logic [31:0]      raddr_full;
  logic [2:0]       raddr_last;
  logic             ld;
  logic [7:0]       ldv;
  logic [7:0]       cur;
  logic [2:0]       cnt_base;

  assign frame_rst        = cs_n | ~rst_b;
  assign rx_bus.quad_mode = snap_qpi_q;

  link_deser u_deser (
    .sck       (sck),
    .rst_b     (rst_b),
    .frame_rst (frame_rst),
    .io_in     (io_in),
    .rx        (rx_bus.deser)
  );

  sync_agree #(.W(1), .INIT(1'b1)) u_sync_cs (
    .clock (clock),
    .rst_b (rst_b),
    .d     (cs_n),
    .q     (cs_hi_s)
  );

  sync_agree #(.W(1), .INIT(1'b1)) u_sync_io3 (
    .clock (clock),
    .rst_b (rst_b),
    .d     (io_in[3]),
    .q     (io3_s)
  );

  sync_agree #(.W(1), .INIT(1'b0)) u_sync_tog (
    .clock (clock),
    .rst_b (rst_b),
    .d     (rx_bus.rx_toggle),
    .q     (tog_s)
  );

  // Byte and first flag are held stable until the next byte completes
  assign rx_evt   = tog_s != tog_seen_q;
  assign op_evt   = rx_evt & rx_bus.rx_first;
  assign data_evt = rx_evt & ~rx_bus.rx_first;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) tog_seen_q <= 1'b0;
    else        tog_seen_q <= tog_s;
  end

  // Power-on copy happens on the first edge after release
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) load_pending_q <= 1'b1;
    else        load_pending_q <= 1'b0;
  end

  assign armed = cfg2_q[`CFG2_THIRD_IO_RESET_ENABLE] &
                 (cs_hi_s | ~(cfg2_q[`CFG2_QPI] | quad_enable) | ~cfg2_q[`CFG2_QPI]);  // RULE_01

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) hw_rst_q <= 1'b0;
    else        hw_rst_q <= armed & ~io3_s;  // RULE_01
  end

  assign reload = load_pending_q | soft_reset | hw_rst_q;

  assign addr_last = cfg2_q[`CFG2_ADS] ? 3'h3 : 3'h2;  // RULE_11

  always_comb begin
    wr2_en = data_evt & (((state_q == CMD_WR_REGS) & (idx_q == `WRR_POS_CFG2)) |
                         ((state_q == CMD_WR_ANY_DATA) & (addr_q == `ADDR_CFG2V)));
    wr3_en = data_evt & (((state_q == CMD_WR_REGS) & (idx_q == `WRR_POS_CFG3)) |
                         ((state_q == CMD_WR_ANY_DATA) & (addr_q == `ADDR_CFG3V)) |
                         (state_q == CMD_BURST));  // RULE_18
  end

  // Command tracking per frame
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= CMD_IDLE;
      idx_q   <= 3'h0;
      acnt_q  <= 3'h0;
      addr_q  <= 32'h00000000;
    end else if (reload) begin
      state_q <= CMD_IDLE;
    end else if (op_evt) begin
      idx_q  <= 3'h1;
      acnt_q <= 3'h0;
      addr_q <= 32'h00000000;
      case (rx_bus.rx_byte)
        `OP_WR_REGS:   state_q <= wel_q ? CMD_WR_REGS : CMD_DONE;  // RULE_15
        `OP_WR_ANY:    state_q <= wel_q ? CMD_WR_ANY_ADDR : CMD_DONE;  // RULE_15
        `OP_SET_BURST: state_q <= CMD_BURST;
        default:       state_q <= CMD_DONE;
      endcase
    end else if (data_evt) begin
      case (state_q)
        CMD_WR_REGS: begin
          idx_q <= idx_q + 3'h1;
          if (idx_q == `WRR_POS_CFG3) state_q <= CMD_DONE;
        end
        CMD_WR_ANY_ADDR: begin
          addr_q <= {addr_q[23:0], rx_bus.rx_byte};
          acnt_q <= acnt_q + 3'h1;
          if (acnt_q == addr_last) state_q <= CMD_WR_ANY_DATA;  // RULE_11
        end
        CMD_WR_ANY_DATA: state_q <= CMD_DONE;
        CMD_BURST:       state_q <= CMD_DONE;
        default:         state_q <= state_q;
      endcase
    end
  end

  // Volatile write enable, consumed by the next register write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wel_q <= 1'b0;
    end else if (reload) begin
      wel_q <= 1'b0;
    end else if (op_evt) begin
      if (rx_bus.rx_byte == `OP_WR_EN_VOL) begin
        wel_q <= 1'b1;
      end else if ((rx_bus.rx_byte == `OP_WR_REGS) || (rx_bus.rx_byte == `OP_WR_ANY)) begin
        wel_q <= 1'b0;  // RULE_15
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg2_q <= `CFG2_RESET;
    end else if (reload) begin
      cfg2_q <= {config2_nonvolatile[7:1], config2_nonvolatile[`CFG2_ADP]} & `CFG2_WR_MASK;  // RULE_11
    end else begin
      if (wr2_en) begin
        cfg2_q <= (rx_bus.rx_byte & `CFG2_WR_MASK) | (cfg2_q & ~`CFG2_WR_MASK);  // RULE_21
      end else if (op_evt) begin
        case (rx_bus.rx_byte)
          `OP_ENTER_QUAD: cfg2_q[`CFG2_QPI] <= 1'b1;  // RULE_05
          `OP_EXIT_QUAD:  cfg2_q[`CFG2_QPI] <= 1'b0;  // RULE_05
          `OP_ENTER_WIDE: cfg2_q[`CFG2_ADS] <= 1'b1;  // RULE_12
          `OP_EXIT_WIDE:  cfg2_q[`CFG2_ADS] <= 1'b0;  // RULE_12
          default:        cfg2_q <= cfg2_q;
        endcase
      end
      if (nv_update) cfg2_q[`CFG2_ADS] <= config2_nonvolatile[`CFG2_ADP];  // RULE_13
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b)      cfg3_q <= `CFG3_RESET;
    else if (reload) cfg3_q <= config3_nonvolatile;  // RULE_16
    else if (wr3_en) cfg3_q <= rx_bus.rx_byte;  // RULE_18
  end

  // Reserved bit reads zero, boot length mirrors the nonvolatile bit
  assign cfg2_rd = {cfg2_q[7:5], 1'b0, cfg2_q[`CFG2_QPI], cfg2_q[`CFG2_WPS],
                    config2_nonvolatile[`CFG2_ADP], cfg2_q[`CFG2_ADS]};  // RULE_10 RULE_19

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b)      array_rd_q <= 1'b0;
    else if (op_evt) array_rd_q <= (rx_bus.rx_byte == `OP_QUAD_RD) || (rx_bus.rx_byte == `OP_QUAD_RD_WIDE);
  end

  // Mode change settles before the link may see it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      qpi_seen_q <= 1'b0;
      settle_q   <= '0;
    end else if (cfg2_q[`CFG2_QPI] != qpi_seen_q) begin
      qpi_seen_q <= cfg2_q[`CFG2_QPI];
      settle_q   <= CNT_W'(QEN_CYC);  // RULE_20
    end else if (settle_q != '0) begin
      settle_q   <= settle_q - CNT_W'(1);
    end
  end

  // Snapshot for the link side, frozen while a frame runs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      snap_cfg2_q <= `CFG2_RESET;
      snap_cfg3_q <= `CFG3_RESET;
      snap_qpi_q  <= 1'b0;
      snap_ads_q  <= 1'b0;
    end else if (cs_hi_s && (settle_q == '0)) begin
      snap_cfg2_q <= cfg2_rd;
      snap_cfg3_q <= cfg3_q;
      snap_qpi_q  <= qpi_seen_q;  // RULE_20
      snap_ads_q  <= cfg2_q[`CFG2_ADS];
    end
  end

  always_comb begin
    if (cfg2_q[`CFG2_QPI])  lm_d = LINE_QUAD_CMD;  // RULE_08
    else if (quad_enable)   lm_d = LINE_QUAD;  // RULE_07
    else                    lm_d = LINE_SINGLE;  // RULE_06
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      config2_volatile      <= `CFG2_RESET;
      config3_volatile      <= `CFG3_RESET;
      drive_strength_select <= 2'h0;
      protect_method_select <= 1'b0;
      current_addr_len      <= 1'b0;
      quad_active           <= 1'b0;
      line_mode             <= 2'h0;
      wp_on_io2             <= 1'b1;
      io3_reset_armed       <= 1'b0;
      device_reset          <= 1'b1;
      array_wrap_active     <= 1'b0;
    end else begin
      config2_volatile      <= cfg2_rd;
      config3_volatile      <= cfg3_q;
      drive_strength_select <= cfg2_q[`CFG2_DRV_HI:`CFG2_DRV_LO];  // RULE_02
      protect_method_select <= cfg2_q[`CFG2_WPS];  // RULE_09
      current_addr_len      <= cfg2_q[`CFG2_ADS];  // RULE_11
      quad_active           <= cfg2_q[`CFG2_QPI] | quad_enable;  // RULE_04
      line_mode             <= lm_d;
      wp_on_io2             <= (lm_d == LINE_SINGLE);  // RULE_06
      io3_reset_armed       <= armed;
      device_reset          <= reload;
      array_wrap_active     <= array_rd_q & ~cfg3_q[`CFG3_WRAP_DIS] & ~cs_hi_s;  // RULE_17
    end
  end

  // Link side: read answers launched on falling edges
  assign raddr_full = {raddr_q[23:0], rx_bus.rx_byte};
  assign raddr_last = snap_ads_q ? 3'h3 : 3'h2;

  always_comb begin
    ld  = 1'b0;
    ldv = 8'h00;
    if (rx_bus.rx_done) begin
      if (rx_bus.rx_first) begin
        case (rx_bus.rx_byte)
          `OP_RD_CFG2: begin
            ld  = 1'b1;
            ldv = snap_cfg2_q;  // RULE_14
          end
          `OP_RD_CFG3: begin
            ld  = 1'b1;
            ldv = snap_cfg3_q;  // RULE_18
          end
          default: ld = 1'b0;
        endcase
      end else if (rd_any_q && (racnt_q == raddr_last)) begin
        ld = 1'b1;
        if (raddr_full == `ADDR_CFG2V)      ldv = snap_cfg2_q;  // RULE_14
        else if (raddr_full == `ADDR_CFG3V) ldv = snap_cfg3_q;
      end
    end
    cnt_base = ld ? 3'h0 : tx_cnt_q;
    cur      = ld ? ldv : ((tx_cnt_q == 3'h0) ? tx_val_q : tx_sh_q);
  end

  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      rd_any_q <= 1'b0;
      racnt_q  <= 3'h0;
      raddr_q  <= 32'h00000000;
    end else if (rx_bus.rx_done) begin
      if (rx_bus.rx_first) begin
        rd_any_q <= (rx_bus.rx_byte == `OP_RD_ANY);
        racnt_q  <= 3'h0;
        raddr_q  <= 32'h00000000;
      end else if (rd_any_q) begin
        raddr_q <= raddr_full;
        racnt_q <= racnt_q + 3'h1;
        if (racnt_q == raddr_last) rd_any_q <= 1'b0;
      end
    end
  end

  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      tx_act_q <= 1'b0;
      tx_val_q <= 8'h00;
      tx_sh_q  <= 8'h00;
      tx_cnt_q <= 3'h0;
      out_q    <= 4'h0;
      oe_q     <= 4'h0;
    end else if (ld || tx_act_q) begin
      tx_act_q <= 1'b1;
      if (ld) tx_val_q <= ldv;
      if (snap_qpi_q) begin
        out_q    <= cur[7:4];  // RULE_03
        tx_sh_q  <= {cur[3:0], 4'h0};
        tx_cnt_q <= cnt_base + 3'h4;
        oe_q     <= 4'hF;
      end else begin
        out_q    <= {2'b00, cur[7], 1'b0};
        tx_sh_q  <= {cur[6:0], 1'b0};
        tx_cnt_q <= cnt_base + 3'h1;
        oe_q     <= 4'h2;
      end
    end
  end

  assign io_out = out_q;
  assign io_oe  = oe_q;
endmodule // cfg2_mode_ctl

/* tb/cfg2_mode_ctl_asserts.sv */
module cfg2_mode_ctl_chk (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       cs_n,
  input wire logic [3:0] io_oe,
  input wire logic [7:0] config2_nonvolatile,
  input wire logic [7:0] config2_volatile,
  input wire logic [7:0] config3_volatile,
  input wire logic       nv_update,
  input wire logic       quad_enable,
  input wire logic       soft_reset,
  input wire logic [1:0] drive_strength_select,
  input wire logic       protect_method_select,
  input wire logic       current_addr_len,
  input wire logic       quad_active,
  input wire logic [1:0] line_mode,
  input wire logic       wp_on_io2,
  input wire logic       io3_reset_armed,
  input wire logic       device_reset,
  input wire logic       array_wrap_active
);
  logic [1:0] up_q;

  // Cycles since reset release, saturating
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  wp_mode_a: assert property (wp_on_io2 == (line_mode == 2'h0)) else $error("wp mode mismatch");
  qpi_quad_a: assert property (line_mode == 2'h2 |-> quad_active && config2_volatile[3])
    else $error("quad command mode without quad");
  field_out_a: assert property (drive_strength_select == config2_volatile[6:5]
    && current_addr_len == config2_volatile[0] && protect_method_select == config2_volatile[2])
    else $error("field outputs disagree");
  rsvd_zero_a: assert property (config2_volatile[4] == 1'b0) else $error("reserved bit set");
  boot_len_a: assert property (up_q == 2'h3 && config2_nonvolatile[1] == $past(config2_nonvolatile[1], 3)
    |-> config2_volatile[1] == config2_nonvolatile[1]) else $error("boot length wrong");
  nv_upd_a: assert property (nv_update |-> ##[1:3] current_addr_len == config2_nonvolatile[1])
    else $error("address length not updated");
  io3_arm_a: assert property (up_q == 2'h3 && !config2_volatile[7] |-> !io3_reset_armed)
    else $error("io3 reset armed while disabled");
  quad_act_a: assert property (up_q == 2'h3 && $past(quad_enable) == quad_enable
    && $past(quad_enable, 2) == quad_enable |-> quad_active == (quad_enable | config2_volatile[3]))
    else $error("quad active wrong");
  soft_rst_a: assert property (soft_reset |-> ##[1:3] device_reset) else $error("no reset after soft reset");
  wrap_reg_a: assert property (up_q == 2'h3 && array_wrap_active |-> !config3_volatile[4])
    else $error("wrap active while disabled");
  oe_idle_a: assert property (cs_n && $past(cs_n) |-> io_oe == 4'h0) else $error("driving while deselected");
endmodule // cfg2_mode_ctl_chk

bind cfg2_mode_ctl cfg2_mode_ctl_chk cfg2_mode_ctl_chk_i (.clock, .rst_b, .cs_n, .io_oe, .config2_nonvolatile,
  .config2_volatile, .config3_volatile, .nv_update, .quad_enable, .soft_reset, .drive_strength_select,
  .protect_method_select, .current_addr_len, .quad_active, .line_mode, .wp_on_io2, .io3_reset_armed,
  .device_reset, .array_wrap_active);

/* tb/spi_host_model.sv */
module spi_host_model (
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] drv;
  logic       quad;

  // Wire level: device drive wins where enabled
  assign io_in = (io_oe & io_out) | (~io_oe & drv);

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    drv = 4'hF;
    quad = 1'b0;
  end

  task start();
    #3 cs_n = 1'b0;
  endtask

  // Mode 0: data set while sck low, sampled by the rise
  task put(input logic [7:0] b);
    int n;
    n = quad ? 2 : 8;
    for (int i = 0; i < n; i++) begin
      drv = quad ? (i == 0 ? b[7:4] : b[3:0]) : {1'b1, ~drv[2:1], b[7 - i]};
      #40 sck = 1'b1;
      #40 sck = 1'b0;
    end
  endtask

  // Released lines other than IO3 toggle so stale data never looks valid; IO3 is held high
  task get(output logic [7:0] b);
    int n;
    n = quad ? 2 : 8;
    for (int i = 0; i < n; i++) begin
      drv = {1'b1, ~drv[2:0]};
      #40 b = quad ? {b[3:0], io_in} : {b[6:0], io_in[1]};
      sck = 1'b1;
      #40 sck = 1'b0;
    end
  endtask

  // Deselect gap covers the mode switch settle time
  task stop();
    #40 cs_n = 1'b1;
    drv = {1'b1, ~drv[2:0]};
    #300;
  endtask

  task io3_pulse();
    drv[3] = 1'b0;
    #200 drv[3] = 1'b1;
    #100;
  endtask
endmodule // spi_host_model

/* tb/cfg2_mode_ctl_tb.sv */
module cfg2_mode_ctl_tb import cfg2_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock, rst_b, nv_update, quad_enable, soft_reset, sck, cs_n, seen;
  logic       quad_active, wp_on_io2, io3_reset_armed, device_reset, array_wrap_active;
  logic       protect_method_select, current_addr_len;
  logic [1:0] drive_strength_select, line_mode;
  logic [3:0] io_in, io_out, io_oe;
  logic [7:0] config2_nonvolatile, config3_nonvolatile, config2_volatile, config3_volatile, r;
  logic [7:0] wv [3] = '{8'hF7, 8'h41, 8'h00};
  int         n_errors, n_checks;

  always #5 clock = ~clock;

  cfg2_mode_ctl #(.T_QEN_NS(50)) cfg2_mode_ctl_i (.clock, .rst_b, .sck, .cs_n, .io_in, .io_out, .io_oe,
    .config2_nonvolatile, .config3_nonvolatile, .nv_update, .quad_enable, .soft_reset, .config2_volatile,
    .config3_volatile, .drive_strength_select, .protect_method_select, .current_addr_len, .quad_active,
    .line_mode, .wp_on_io2, .io3_reset_armed, .device_reset, .array_wrap_active);
  spi_host_model spi_host_model_i (.sck, .cs_n, .io_in, .io_out, .io_oe);

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task frame(input logic [7:0] b [$], input bit want);
    spi_host_model_i.start();
    foreach (b[i]) spi_host_model_i.put(b[i]);
    if (want) spi_host_model_i.get(r);
    spi_host_model_i.stop();
  endtask

  task wr2(input logic [7:0] v);
    frame('{8'h50}, 0);
    frame('{8'h01, 8'h00, 8'h00, v}, 0);
  endtask

  task tick(input logic [7:0] nv2, input bit nv, input bit sr);
    @(posedge clock);
    #1 config2_nonvolatile = nv2;
    {nv_update, soft_reset} = {nv, sr};
    @(posedge clock);
    #1 {nv_update, soft_reset} = 2'h0;
    wt(5);
  endtask

  task io3_try();
    seen = 1'b0;
    fork
      spi_host_model_i.io3_pulse();
      repeat (40) begin
        @(posedge clock);
        #1 if (device_reset === 1'b1) seen = 1'b1;
      end
    join
  endtask

  task final_report();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #500000;
    n_errors++;
    $display("unexpected watchdog expected done seen hang");
    final_report();
  end

  initial begin
    {clock, rst_b, nv_update, quad_enable, soft_reset} = 5'h0;
    config2_nonvolatile = 8'h10;
    config3_nonvolatile = 8'h10;
    wt(20);
    rst_b = 1'b1;
    wt(20);
    chk("cfg2", 8'h00, config2_volatile);
    chk("cfg3", 8'h10, config3_volatile);
    chk("wp", 8'h01, 8'(wp_on_io2));
    frame('{8'h15}, 1);
    chk("rd15", 8'h00, r);
    $display("test reset done");
    foreach (wv[i]) begin
      wr2(wv[i]);
      chk("wr", wv[i] & 8'hED, config2_volatile);
      frame('{8'h15}, 1);
      chk("rd", wv[i] & 8'hED, r);
    end
    frame('{8'h01, 8'h00, 8'h00, 8'h41}, 0);
    chk("nowen", 8'h00, config2_volatile);
    frame('{8'h50}, 0);
    frame('{8'h71, 8'h80, 8'h00, 8'h03, 8'h24}, 0);
    chk("wrany", 8'h24, config2_volatile);
    frame('{8'h01, 8'h00, 8'h00, 8'hE5}, 0);
    chk("once", 8'h24, config2_volatile);
    $display("test write done");
    frame('{8'h65, 8'h80, 8'h00, 8'h03}, 1);
    chk("rdany3", 8'h24, r);
    frame('{8'hB7}, 0);
    chk("ads", 8'h01, 8'(current_addr_len));
    frame('{8'h65, 8'h00, 8'h80, 8'h00, 8'h03}, 1);
    chk("rdany4", 8'h25, r);
    frame('{8'h65, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
    chk("unmapped", 8'h00, r);
    frame('{8'hE9}, 0);
    chk("cfg2", 8'h24, config2_volatile);
    $display("test addr done");
    tick(8'h02, 1, 0);
    chk("nvupd", 8'h27, config2_volatile);
    config3_nonvolatile = 8'h05;
    tick(8'h02, 0, 1);
    chk("reload2", 8'h03, config2_volatile);
    chk("reload3", 8'h05, config3_volatile);
    tick(8'h00, 0, 1);
    $display("test reload done");
    frame('{8'h38}, 0);
    chk("mode", 8'(LINE_QUAD_CMD), 8'(line_mode));
    chk("qa", 8'h01, 8'(quad_active));
    spi_host_model_i.quad = 1'b1;
    frame('{8'h15}, 1);
    chk("rdq", 8'h08, r);
    wt(1);
    quad_enable = 1'b1;
    frame('{8'hF5}, 0);
    spi_host_model_i.quad = 1'b0;
    chk("mode", 8'(LINE_QUAD), 8'(line_mode));
    chk("wp", 8'h00, 8'(wp_on_io2));
    wt(1);
    quad_enable = 1'b0;
    wt(5);
    chk("mode", 8'(LINE_SINGLE), 8'(line_mode));
    $display("test quad done");
    wr2(8'h80);
    chk("armed", 8'h01, 8'(io3_reset_armed));
    io3_try();
    chk("io3rst", 8'h01, 8'(seen));
    chk("cfg2", 8'h00, config2_volatile);
    io3_try();
    chk("io3off", 8'h00, 8'(seen));
    $display("test io3 done");
    frame('{8'h77, 8'h10}, 0);
    chk("cfg3", 8'h10, config3_volatile);
    frame('{8'h33}, 1);
    chk("rd33", 8'h10, r);
    frame('{8'h77, 8'h00}, 0);
    spi_host_model_i.start();
    spi_host_model_i.put(8'hEB);
    wt(10);
    chk("wrap", 8'h01, 8'(array_wrap_active));
    spi_host_model_i.stop();
    spi_host_model_i.start();
    spi_host_model_i.put(8'h15);
    wt(10);
    chk("nowrap", 8'h00, 8'(array_wrap_active));
    spi_host_model_i.stop();
    $display("test wrap done");
    final_report();
  end
endmodule // cfg2_mode_ctl_tb
